//--- hdl/rfcrc_regs.svh
// Purpose: Addresses, field values, presets and polynomials of the frame CRC block.
// Assumes: Byte-wide register port; all values used through these names.
// Notes:   Definitions only.
`ifndef RFCRC_REGS_SVH
`define RFCRC_REGS_SVH

// ********************************************************************
// Register addresses
// ********************************************************************
`define RFCRC_TX_CFG_ADDR   8'h2c
`define RFCRC_RX_CFG_ADDR   8'h2d
`define RFCRC_IRQ_STAT_ADDR 8'h40
`define RFCRC_IRQ_MASK_ADDR 8'h41

// ********************************************************************
// Write masks and reset values
// ********************************************************************
`define RFCRC_TX_CFG_WMASK  8'h7f
`define RFCRC_RX_CFG_WMASK  8'hff
`define RFCRC_IRQ_WMASK     8'h07
`define RFCRC_CFG_RST       8'h00
`define RFCRC_ZERO8         8'h00
`define RFCRC_ZERO16        16'h0000

// ********************************************************************
// Interrupt event bits
// ********************************************************************
`define RFCRC_EV_TX_DONE    0
`define RFCRC_EV_RX_DONE    1
`define RFCRC_EV_RX_ERR     2

// ********************************************************************
// Preset select codes and preset values
// ********************************************************************
`define RFCRC_SEL_ZERO      3'h0
`define RFCRC_SEL_A         3'h1
`define RFCRC_SEL_B         3'h2
`define RFCRC_SEL_C         3'h3
`define RFCRC_SEL_USER      3'h6
`define RFCRC_SEL_ONES      3'h7
`define RFCRC_P16_A         16'h6363
`define RFCRC_P16_B         16'ha671
`define RFCRC_P16_C         16'hfffe
`define RFCRC_P16_ONES      16'hffff
`define RFCRC_P8_A          16'h0012
`define RFCRC_P8_B          16'h00bf
`define RFCRC_P8_C          16'h00fd
`define RFCRC_P8_ONES       16'h00ff
`define RFCRC_P5_A          16'h0012
`define RFCRC_P5_ONES       16'h001f

// ********************************************************************
// Polynomials, bit-reversed for LSB-first shifting, and width masks
// ********************************************************************
`define RFCRC_POLY16        16'h8408
`define RFCRC_POLY8         16'h00b8
`define RFCRC_POLY5         16'h0012
`define RFCRC_MASK16        16'hffff
`define RFCRC_MASK8         16'h00ff
`define RFCRC_MASK5         16'h001f
`define RFCRC_BYTE_BITS     8
`define RFCRC_NB_TWO        2'd2
`define RFCRC_NB_ONE        2'd1
`define RFCRC_NB_NONE       2'd0

`endif

//--- hdl/rfcrc_pkg.sv
// Purpose: Types and shared functions of the frame CRC block.
// Assumes: rfcrc_regs.svh supplies every value.
// Notes:   Config struct mirrors the register bit layout.
`include "rfcrc_regs.svh"

package rfcrc_pkg;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {CRC_KIND_5, CRC_KIND_8, CRC_KIND_16, CRC_KIND_RSVD} rfcrc_kind_t;

  typedef struct packed {
    logic        store;
    logic [2:0]  init_sel;
    rfcrc_kind_t kind;
    logic        negate;
    logic        on;
  } rfcrc_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } rfcrc_byte_t;

  // ******************************************************************
  // Functions
  // ******************************************************************
  function automatic logic [15:0] rfcrc_mask(input rfcrc_kind_t kind);
    unique case (kind)
      CRC_KIND_5:  rfcrc_mask = `RFCRC_MASK5;
      CRC_KIND_8:  rfcrc_mask = `RFCRC_MASK8;
      CRC_KIND_16: rfcrc_mask = `RFCRC_MASK16;
      default:     rfcrc_mask = `RFCRC_ZERO16;
    endcase
  endfunction : rfcrc_mask

  function automatic logic [1:0] rfcrc_nbytes(input rfcrc_kind_t kind);
    unique case (kind)
      CRC_KIND_16:          rfcrc_nbytes = `RFCRC_NB_TWO;
      CRC_KIND_5, CRC_KIND_8: rfcrc_nbytes = `RFCRC_NB_ONE;
      default:              rfcrc_nbytes = `RFCRC_NB_NONE;
    endcase
  endfunction : rfcrc_nbytes

  // Undefined codes load zero so a bad setting still gives a repeatable result.
  function automatic logic [15:0] rfcrc_preset(input rfcrc_kind_t kind, input logic [2:0] sel,
                                               input logic [15:0] user);
    rfcrc_preset = `RFCRC_ZERO16;
    case (kind)
      CRC_KIND_16: begin
        case (sel)
          `RFCRC_SEL_A:    rfcrc_preset = `RFCRC_P16_A;
          `RFCRC_SEL_B:    rfcrc_preset = `RFCRC_P16_B;
          `RFCRC_SEL_C:    rfcrc_preset = `RFCRC_P16_C;
          `RFCRC_SEL_USER: rfcrc_preset = user;
          `RFCRC_SEL_ONES: rfcrc_preset = `RFCRC_P16_ONES;
          default:         rfcrc_preset = `RFCRC_ZERO16;
        endcase
      end
      CRC_KIND_8: begin
        case (sel)
          `RFCRC_SEL_A:    rfcrc_preset = `RFCRC_P8_A;
          `RFCRC_SEL_B:    rfcrc_preset = `RFCRC_P8_B;
          `RFCRC_SEL_C:    rfcrc_preset = `RFCRC_P8_C;
          `RFCRC_SEL_USER: rfcrc_preset = user & `RFCRC_MASK8;
          `RFCRC_SEL_ONES: rfcrc_preset = `RFCRC_P8_ONES;
          default:         rfcrc_preset = `RFCRC_ZERO16;
        endcase
      end
      CRC_KIND_5: begin
        case (sel)
          `RFCRC_SEL_A:    rfcrc_preset = `RFCRC_P5_A;
          `RFCRC_SEL_USER: rfcrc_preset = user & `RFCRC_MASK5;
          `RFCRC_SEL_ONES: rfcrc_preset = `RFCRC_P5_ONES;
          default:         rfcrc_preset = `RFCRC_ZERO16;
        endcase
      end
      default: rfcrc_preset = `RFCRC_ZERO16;
    endcase
  endfunction : rfcrc_preset

endpackage : rfcrc_pkg

//--- hdl/rfcrc_engine.sv
// Purpose: One-byte CRC update for CRC5, CRC8 and CRC16, LSB first.
// Assumes: Pure combinational; caller holds the CRC register.
// Notes:   Reflected register form lets all widths share one shifter.
`timescale 1ns/10ps
`include "rfcrc_regs.svh"

module rfcrc_engine
  import rfcrc_pkg::*;
(
  // Inputs
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data,
  input  rfcrc_kind_t      kind,
  // Result
  output logic [15:0]      crc_out
);

  logic [15:0] poly;
  logic [15:0] c;
  logic        fb;

  always_comb begin
    unique case (kind)
      CRC_KIND_5:  poly = `RFCRC_POLY5;
      CRC_KIND_8:  poly = `RFCRC_POLY8;
      CRC_KIND_16: poly = `RFCRC_POLY16;
      default:     poly = `RFCRC_ZERO16;
    endcase
  end

  always_comb begin
    c  = crc_in & rfcrc_mask(kind);
    fb = 1'b0;
    for (int i = 0; i < `RFCRC_BYTE_BITS; i++) begin
      fb = c[0] ^ data[i];
      c  = c >> 1;
      if (fb) begin
        c = c ^ poly;
      end
    end
    crc_out = c;
  end

endmodule : rfcrc_engine

//--- hdl/rfcrc_core.sv
// Purpose: CRC append on transmit and CRC check on receive for RF frames.
// Assumes: Framer byte streams and register port share core_clk.
// Notes:   CRC bytes go out and come in low byte first.
//
// Contract
// - The transmit preset field in bits 6 to 4 picks the start value of the transmit CRC.
// - The two-bit kind field selects CRC5 for 0, CRC8 for 1, CRC16 for 2, and 3 is reserved.
// - With transmit negate set the computed CRC is inverted before it is appended.
// - With transmit append set the CRC follows the data, and with it clear nothing is appended.
// - CRC16 presets for codes 0, 1, 2, 3 and 7 are 0000h, 6363h, A671h, FFFEh and FFFFh on both paths.
// - CRC8 presets are 00h, 12h, BFh, FDh and FFh, and CRC5 presets for 0, 1 and 7 are 00h, 12h and 1Fh.
// - Preset code 6 takes a user value from nonvolatile storage, and codes 4 and 5 have no value.
// - The receive preset field in bits 6 to 4 picks the start value of the receive checker.
// - With receive store set the CRC bytes go to the FIFO, otherwise they are only checked.
// - With receive negate set the frame is checked against the inverted computed CRC.
// - With receive check set a mismatch raises the error flag, otherwise the flag is left alone.
`timescale 1ns/10ps
`include "rfcrc_regs.svh"

module rfcrc_core
  import rfcrc_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic   reg_wr,
  input  wire logic   reg_rd,
  output logic [7:0]  reg_rdata,
  // Nonvolatile user preset
  input  wire logic [15:0] nv_user_preset,
  // Transmit stream
  input  wire logic   tx_start,
  input  rfcrc_byte_t tx_in,
  output logic        tx_in_ready,
  output rfcrc_byte_t tx_out,
  // Receive stream
  input  wire logic   rx_start,
  input  rfcrc_byte_t rx_in,
  output rfcrc_byte_t rx_fifo_out,
  output logic        rx_crc_fail,
  // Interrupt
  output logic        irq
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  typedef enum logic [1:0] {TX_PASS, TX_CRC_LO, TX_CRC_HI} rfcrc_tx_state_t;

  rfcrc_cfg_t      tx_cfg_ff;
  rfcrc_cfg_t      rx_cfg_ff;
  logic [7:0]      irq_stat_ff;
  logic [7:0]      irq_mask_ff;
  logic [7:0]      rdata_ff;
  logic [7:0]      nxt_rdata;
  logic [7:0]      ev_set;
  rfcrc_tx_state_t tx_state_ff;
  rfcrc_tx_state_t nxt_tx_state;
  logic [15:0]     tx_crc_ff;
  logic [15:0]     tx_crc_upd;
  logic [15:0]     tx_final;
  rfcrc_byte_t     tx_out_ff;
  rfcrc_byte_t     nxt_tx_out;
  logic [1:0]      tx_n;
  logic            tx_take;
  logic            tx_tail;
  logic [15:0]     rx_crc_ff;
  logic [15:0]     rx_crc_upd;
  logic [15:0]     rx_calc;
  logic [15:0]     rx_expect;
  logic [15:0]     rx_recv;
  logic [7:0]      rx_h0_ff;
  logic [7:0]      rx_h1_ff;
  logic [1:0]      rx_cnt_ff;
  logic [1:0]      rx_n;
  logic [7:0]      rx_oldest;
  logic            rx_emit;
  logic            rx_end;
  logic            rx_check;
  logic            rx_mismatch;
  rfcrc_byte_t     rx_fifo_ff;
  logic            rx_fail_ff;

  wire wr_tx   = reg_wr && (reg_addr == `RFCRC_TX_CFG_ADDR);
  wire wr_rx   = reg_wr && (reg_addr == `RFCRC_RX_CFG_ADDR);
  wire wr_stat = reg_wr && (reg_addr == `RFCRC_IRQ_STAT_ADDR);
  wire wr_mask = reg_wr && (reg_addr == `RFCRC_IRQ_MASK_ADDR);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_cfg_ff <= `RFCRC_CFG_RST;
      rx_cfg_ff <= `RFCRC_CFG_RST;
    end else begin
      if (wr_tx) begin
        tx_cfg_ff <= reg_wdata & `RFCRC_TX_CFG_WMASK;
      end
      if (wr_rx) begin
        rx_cfg_ff <= reg_wdata & `RFCRC_RX_CFG_WMASK;
      end
    end
  end

  // Unmapped addresses read as zero; the bus never waits.
  always_comb begin
    nxt_rdata = `RFCRC_ZERO8;
    if (reg_rd) begin
      case (reg_addr)
        `RFCRC_TX_CFG_ADDR:   nxt_rdata = tx_cfg_ff;
        `RFCRC_RX_CFG_ADDR:   nxt_rdata = rx_cfg_ff;
        `RFCRC_IRQ_STAT_ADDR: nxt_rdata = irq_stat_ff;
        `RFCRC_IRQ_MASK_ADDR: nxt_rdata = irq_mask_ff;
        default:              nxt_rdata = `RFCRC_ZERO8;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_ff <= `RFCRC_ZERO8;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ******************************************************************
  // Interrupts
  // ******************************************************************
  always_comb begin
    ev_set = `RFCRC_ZERO8;
    ev_set[`RFCRC_EV_TX_DONE] = tx_out_ff.valid && tx_out_ff.last;
    ev_set[`RFCRC_EV_RX_DONE] = rx_end;
    ev_set[`RFCRC_EV_RX_ERR]  = rx_end && rx_check && rx_mismatch;
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_ff <= `RFCRC_ZERO8;
      irq_mask_ff <= `RFCRC_ZERO8;
    end else begin
      irq_stat_ff <= ((irq_stat_ff & ~(wr_stat ? reg_wdata : `RFCRC_ZERO8)) | ev_set) & `RFCRC_IRQ_WMASK;
      if (wr_mask) begin
        irq_mask_ff <= reg_wdata & `RFCRC_IRQ_WMASK;
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ******************************************************************
  // Transmit path
  // ******************************************************************
  rfcrc_engine u_tx_engine (
    .crc_in  (tx_crc_ff),
    .data    (tx_in.data),
    .kind    (tx_cfg_ff.kind),
    .crc_out (tx_crc_upd)
  );

  assign tx_n        = rfcrc_nbytes(tx_cfg_ff.kind);
  assign tx_in_ready = (tx_state_ff == TX_PASS);
  assign tx_take     = tx_in.valid && tx_in_ready;
  assign tx_tail     = tx_take && tx_in.last && tx_cfg_ff.on && (tx_n != `RFCRC_NB_NONE);
  assign tx_final    = (tx_cfg_ff.negate ? ~tx_crc_ff : tx_crc_ff) & rfcrc_mask(tx_cfg_ff.kind);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_crc_ff <= `RFCRC_ZERO16;
    end else if (tx_start) begin
      tx_crc_ff <= rfcrc_preset(tx_cfg_ff.kind, tx_cfg_ff.init_sel, nv_user_preset);
    end else if (tx_take) begin
      tx_crc_ff <= tx_crc_upd;
    end
  end

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_out   = '0;
    unique case (tx_state_ff)
      TX_PASS: begin
        nxt_tx_out.valid = tx_take;
        nxt_tx_out.data  = tx_in.data;
        nxt_tx_out.last  = tx_take && tx_in.last && !tx_tail;
        if (tx_tail) begin
          nxt_tx_state = TX_CRC_LO;
        end
      end
      TX_CRC_LO: begin
        nxt_tx_out.valid = 1'b1;
        nxt_tx_out.data  = tx_final[7:0];
        nxt_tx_out.last  = (tx_n != `RFCRC_NB_TWO);
        nxt_tx_state     = (tx_n == `RFCRC_NB_TWO) ? TX_CRC_HI : TX_PASS;
      end
      TX_CRC_HI: begin
        nxt_tx_out.valid = 1'b1;
        nxt_tx_out.data  = tx_final[15:8];
        nxt_tx_out.last  = 1'b1;
        nxt_tx_state     = TX_PASS;
      end
      default: nxt_tx_state = TX_PASS;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_ff <= TX_PASS;
      tx_out_ff   <= '0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_out_ff   <= nxt_tx_out;
    end
  end

  assign tx_out = tx_out_ff;

  // ******************************************************************
  // Receive path
  // ******************************************************************
  // The last rx_n bytes are held back, so only bytes known to be data feed the checker.
  assign rx_n      = rfcrc_nbytes(rx_cfg_ff.kind);
  assign rx_oldest = (rx_n == `RFCRC_NB_TWO) ? rx_h1_ff : (rx_n == `RFCRC_NB_ONE) ? rx_h0_ff : rx_in.data;
  assign rx_emit   = rx_in.valid && (rx_cnt_ff == rx_n);
  assign rx_end    = rx_in.valid && rx_in.last;
  assign rx_check  = rx_cfg_ff.on && (rx_n != `RFCRC_NB_NONE);

  rfcrc_engine u_rx_engine (
    .crc_in  (rx_crc_ff),
    .data    (rx_oldest),
    .kind    (rx_cfg_ff.kind),
    .crc_out (rx_crc_upd)
  );

  assign rx_calc     = rx_emit ? rx_crc_upd : rx_crc_ff;
  assign rx_expect   = (rx_cfg_ff.negate ? ~rx_calc : rx_calc) & rfcrc_mask(rx_cfg_ff.kind);
  assign rx_recv     = ((rx_n == `RFCRC_NB_TWO) ? {rx_in.data, rx_h0_ff} : {`RFCRC_ZERO8, rx_in.data})
                       & rfcrc_mask(rx_cfg_ff.kind);
  assign rx_mismatch = (rx_recv != rx_expect) || (rx_cnt_ff != rx_n);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_crc_ff <= `RFCRC_ZERO16;
    end else if (rx_start) begin
      rx_crc_ff <= rfcrc_preset(rx_cfg_ff.kind, rx_cfg_ff.init_sel, nv_user_preset);
    end else if (rx_emit) begin
      rx_crc_ff <= rx_crc_upd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_h0_ff  <= `RFCRC_ZERO8;
      rx_h1_ff  <= `RFCRC_ZERO8;
      rx_cnt_ff <= `RFCRC_NB_NONE;
    end else if (rx_start) begin
      rx_cnt_ff <= `RFCRC_NB_NONE;
    end else if (rx_in.valid) begin
      rx_h1_ff  <= rx_h0_ff;
      rx_h0_ff  <= rx_in.data;
      if (rx_in.last) begin
        rx_cnt_ff <= `RFCRC_NB_NONE;
      end else if (rx_cnt_ff != rx_n) begin
        rx_cnt_ff <= rx_cnt_ff + `RFCRC_NB_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_fifo_ff <= '0;
    end else if (rx_cfg_ff.store) begin
      rx_fifo_ff <= rx_in;
    end else begin
      rx_fifo_ff.valid <= rx_emit;
      rx_fifo_ff.last  <= rx_emit && rx_in.last;
      rx_fifo_ff.data  <= rx_oldest;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_fail_ff <= 1'b0;
    end else if (rx_end && rx_check) begin
      rx_fail_ff <= rx_mismatch;
    end
  end

  assign rx_fifo_out = rx_fifo_ff;
  assign rx_crc_fail = rx_fail_ff;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_crc16_tail;
    tx_out.valid && !tx_out.last ##1 tx_out.valid && tx_out.last;
  endsequence

  sequence s_data_then_tail;
    tx_out.valid && !tx_out.last ##1 s_crc16_tail;
  endsequence

  chk_tx_preset_sel: assert property (tx_start |=> tx_crc_ff ==
      rfcrc_preset($past(tx_cfg_ff.kind), $past(tx_cfg_ff.init_sel), $past(nv_user_preset)))
    else $error("transmit preset not loaded");
  chk_crc16_two_bytes: assert property (tx_tail && tx_cfg_ff.kind == CRC_KIND_16
      |=> s_data_then_tail)
    else $error("crc16 tail is not two bytes");
  chk_tx_negate_lo: assert property (tx_state_ff == TX_CRC_LO && tx_cfg_ff.negate
      && tx_cfg_ff.kind == CRC_KIND_8 |=> tx_out.data == ~$past(tx_crc_ff[7:0]))
    else $error("appended crc not inverted");
  chk_tx_no_append: assert property (tx_take && tx_in.last && !tx_cfg_ff.on
      |=> tx_out.last ##1 !tx_out.valid)
    else $error("crc appended while disabled");
  chk_crc16_preset_a: assert property (tx_start && tx_cfg_ff.kind == CRC_KIND_16
      && tx_cfg_ff.init_sel == `RFCRC_SEL_A |=> tx_crc_ff == `RFCRC_P16_A)
    else $error("crc16 preset code 1 wrong");
  chk_crc5_preset_ones: assert property (rx_start && rx_cfg_ff.kind == CRC_KIND_5
      && rx_cfg_ff.init_sel == `RFCRC_SEL_ONES |=> rx_crc_ff == `RFCRC_P5_ONES)
    else $error("crc5 preset code 7 wrong");
  chk_user_preset: assert property (rx_start && rx_cfg_ff.kind == CRC_KIND_16
      && rx_cfg_ff.init_sel == `RFCRC_SEL_USER |=> rx_crc_ff == $past(nv_user_preset))
    else $error("user preset not taken");
  chk_rx_preset_sel: assert property (rx_start |=> rx_cnt_ff == `RFCRC_NB_NONE && rx_crc_ff ==
      rfcrc_preset($past(rx_cfg_ff.kind), $past(rx_cfg_ff.init_sel), $past(nv_user_preset)))
    else $error("receive preset not loaded");
  chk_rx_store_all: assert property (rx_in.valid && rx_cfg_ff.store
      |=> rx_fifo_out.valid && rx_fifo_out.data == $past(rx_in.data))
    else $error("received byte not stored");
  chk_rx_check_off: assert property (rx_end && !rx_cfg_ff.on
      |=> $stable(rx_crc_fail) && !$rose(irq_stat_ff[`RFCRC_EV_RX_ERR]))
    else $error("error flag changed while check off");

endmodule : rfcrc_core

//--- tb/rfcrc_card.sv
// Purpose: Card side model that echoes each sent frame back to the receiver.
// Assumes: One frame in flight; the bench waits for busy to fall.
// Notes:   Bit 0 of the first byte is flipped on request to break the CRC.
`timescale 1ns/10ps

module rfcrc_card
  import rfcrc_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  // Bench control
  input  wire logic  echo_on,
  input  wire logic  corrupt,
  // Frame traffic
  input  rfcrc_byte_t tx_out,
  output rfcrc_byte_t rx_in,
  output logic       rx_start,
  output logic       busy
);
  logic [7:0] got[$];

  initial begin
    rx_in    = '0;
    rx_start = 1'b0;
    busy     = 1'b0;
    forever begin
      @(posedge core_clk);
      if (rst_n && echo_on && tx_out.valid) begin
        busy <= 1'b1;
        got.push_back(tx_out.data);
        if (tx_out.last) begin
          rx_start <= 1'b1;
          @(posedge core_clk);
          rx_start <= 1'b0;
          for (int i = 0; i < got.size(); i++) begin
            rx_in <= '{valid: 1'b1, last: i == got.size() - 1, data: got[i] ^ {7'h00, corrupt && i == 0}};
            @(posedge core_clk);
          end
          // A released line shows the inverse, so a stale byte is never taken for data.
          rx_in <= '{valid: 1'b0, last: 1'b0, data: ~got[got.size() - 1]};
          got.delete();
          busy <= 1'b0;
        end
      end
    end
  end
endmodule : rfcrc_card

//--- tb/testbench.sv
// Purpose: Self-checking bench of the frame CRC block.
// Assumes: Host writes rx preset, kind and negate to match tx, so echoed frames check clean unless corrupted.
// Notes:   Expected bytes are queued by the driver and popped by the monitor.
`timescale 1ns/10ps

module testbench
  import rfcrc_pkg::*;
;
  logic        core_clk       = 1'b0;
  logic        rst_n          = 1'b0;
  logic [7:0]  reg_addr       = 8'h00;
  logic [7:0]  reg_wdata      = 8'h00;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] nv_user_preset = 16'h0000;
  logic        tx_start       = 1'b0;
  rfcrc_byte_t tx_in          = '0;
  logic        tx_in_ready, rx_start, rx_crc_fail, irq, busy;
  rfcrc_byte_t tx_out, rx_in, rx_fifo_out;
  logic        echo_on = 1'b0;
  logic        corrupt = 1'b0;
  logic        rd_pend = 1'b0;
  logic        fail_exp = 1'b0;
  logic [8:0]  exp_tx[$];
  logic [8:0]  exp_rx[$];
  logic [7:0]  exp_rd[$];
  logic [7:0]  ra[5] = '{8'h2c, 8'h2d, 8'h40, 8'h41, 8'h55};
  int          err_count = 0;
  int          compares = 0;
  int          seed = 32'h84603ac9;

  always #25 core_clk = ~core_clk;

  rfcrc_core rfcrc_core_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nv_user_preset, .tx_start, .tx_in, .tx_in_ready, .tx_out, .rx_start, .rx_in, .rx_fifo_out,
    .rx_crc_fail, .irq);
  rfcrc_card rfcrc_card_i (.core_clk, .rst_n, .echo_on, .corrupt, .tx_out, .rx_in, .rx_start, .busy);

  // ******
  // Checking
  // ******
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    if (rd_pend) chk({8'h00, reg_rdata}, {8'h00, exp_rd.pop_front()});
    rd_pend <= reg_rd;
    if (rst_n && tx_out.valid !== 1'b0)
      chk({7'h00, tx_out.last, tx_out.data}, {7'h00, exp_tx.pop_front()});
    if (rst_n && rx_fifo_out.valid !== 1'b0)
      chk({7'h00, rx_fifo_out.last, rx_fifo_out.data}, {7'h00, exp_rx.pop_front()});
  end

  // ******
  // Register port and reference
  // ******
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask : rd

  function automatic logic [15:0] wmask(input int k);
    return (k == 0) ? 16'h001f : (k == 1) ? 16'h00ff : 16'hffff;
  endfunction : wmask

  function automatic logic [15:0] init_val(input int k, input int s);
    logic [15:0] v;
    case (s)
      1: v = (k == 2) ? 16'h6363 : 16'h0012;
      2: v = (k == 2) ? 16'ha671 : (k == 1) ? 16'h00bf : 16'h0000;
      3: v = (k == 2) ? 16'hfffe : (k == 1) ? 16'h00fd : 16'h0000;
      6: v = nv_user_preset;
      7: v = 16'hffff;
      default: v = 16'h0000;
    endcase
    return v & wmask(k);
  endfunction : init_val

  function automatic logic [15:0] crc_of(input int k, input logic [15:0] c, input logic [7:0] b[$]);
    logic [15:0] p;
    p = (k == 0) ? 16'h0012 : (k == 1) ? 16'h00b8 : 16'h8408;
    foreach (b[j]) for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[j][i]) ? p : 16'h0000);
    return c;
  endfunction : crc_of

  // ******
  // One frame out and, when it carries a CRC, back in
  // ******
  task automatic frame(input int k, input int s);
    logic [7:0]  d[$];
    logic [31:0] r;
    logic [15:0] c;
    logic [7:0]  cfg;
    logic [2:0]  msk, stat;
    logic        on, neg, rxon, st, bad, ech;
    int          n, nb;
    r    = $random(seed);
    on   = r[1:0] != 2'b00;
    neg  = r[2];
    rxon = r[3];
    bad  = r[4];
    msk  = r[7:5];
    st   = (k == 0) || r[8];
    n    = 1 + int'(r[10:9]);
    ech  = on && k < 3;
    nb   = ech ? ((k == 2) ? 2 : 1) : 0;
    corrupt <= bad;
    echo_on <= ech;
    cfg = {1'b0, s[2:0], k[1:0], neg, on};
    wr(8'h2c, cfg);
    rd(8'h2c, cfg);
    wr(8'h2d, {st, s[2:0], k[1:0], neg, rxon});
    wr(8'h41, {5'h00, msk});
    for (int i = 0; i < n; i++) d.push_back(8'($random(seed)));
    c = crc_of(k, init_val(k, s), d) ^ (neg ? wmask(k) : 16'h0000);
    for (int i = 0; i < n; i++) begin
      exp_tx.push_back({nb == 0 && i == n - 1, d[i]});
      if (ech) exp_rx.push_back({!st && i == n - 1, d[i] ^ {7'h00, bad && i == 0}});
    end
    for (int i = 0; i < nb; i++) begin
      exp_tx.push_back({i == nb - 1, c[8*i +: 8]});
      if (st) exp_rx.push_back({i == nb - 1, c[8*i +: 8]});
    end
    @(posedge core_clk);
    tx_start <= 1'b1;
    @(posedge core_clk);
    tx_start <= 1'b0;
    foreach (d[i]) begin
      tx_in <= '{valid: 1'b1, last: i == n - 1, data: d[i]};
      @(posedge core_clk);
      chk({15'h0000, tx_in_ready}, 16'h0001);
    end
    tx_in <= '{valid: 1'b0, last: 1'b0, data: ~d[n - 1]};
    @(posedge core_clk);
    chk({15'h0000, tx_in_ready}, {15'h0000, nb == 0});
    for (int t = 0; t < 60 && (busy || exp_tx.size() != 0 || exp_rx.size() != 0); t++) @(posedge core_clk);
    if (busy || exp_tx.size() != 0 || exp_rx.size() != 0) begin
      err_count++;
      wrap_up();
    end
    repeat (2) @(posedge core_clk);
    if (ech && rxon) fail_exp = bad;
    chk({15'h0000, rx_crc_fail}, {15'h0000, fail_exp});
    stat = {bad && ech && rxon, ech, 1'b1};
    rd(8'h40, {5'h00, stat});
    chk({15'h0000, irq}, {15'h0000, |(stat & msk)});
    wr(8'h40, 8'h07);
    @(posedge core_clk);
    chk({15'h0000, irq}, 16'h0000);
    $display("frame kind %0d preset %0d done", k, s);
  endtask : frame

  initial begin
    nv_user_preset <= 16'($random(seed));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'h7f);
    wr(8'h2d, 8'hff);
    rd(8'h2d, 8'hff);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    $display("register test done");
    for (int k = 0; k < 4; k++) for (int s = 0; s < 8; s++) frame(k, s);
    repeat (2) @(posedge core_clk);
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
endmodule : testbench
